// ---- inc/pds_pkg.sv ----
// package: register map, field layout and carrier types of the photodiode input select block
package pds_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] PDS_INPUT_CONFIG_OFS = 8'h08;
   localparam logic [7:0] PDS_SEQ_CONFIG_OFS   = 8'h20;
   localparam logic [7:0] PDS_IRQ_STATUS_OFS   = 8'h40;
   localparam logic [7:0] PDS_IRQ_MASK_OFS     = 8'h44;

   // ----------------------------------------------------------------
   // photodiode_input_config fields
   // ----------------------------------------------------------------
   localparam int PDS_EXT_A_BIT     = 0;
   localparam int PDS_EXT_B_BIT     = 1;
   localparam int PDS_DIODE_LSB     = 2;
   localparam int PDS_DIODE_MSB     = 5;
   localparam int PDS_OFFSET_LSB    = 8;
   localparam int PDS_OFFSET_MSB    = 15;
   localparam int PDS_HEADROOM_LSB  = 20;
   localparam int PDS_HEADROOM_MSB  = 23;
   localparam int PDS_IDLE_HOLD_BIT = 25;

   // ----------------------------------------------------------------
   // sequencer_manual_config fields
   // ----------------------------------------------------------------
   localparam int PDS_SEQ_EN_BIT      = 0;
   localparam int PDS_DIODE_CTRL_LSB  = 16;
   localparam int PDS_DIODE_CTRL_MSB  = 19;
   localparam int PDS_MANUAL_MODE_BIT = 20;
   localparam int PDS_SW_INTEG_BIT    = 21;

   // ----------------------------------------------------------------
   // reset values and widths
   // ----------------------------------------------------------------
   localparam logic [31:0] PDS_INPUT_CONFIG_RST = 32'h0000_0000;
   localparam logic [31:0] PDS_SEQ_CONFIG_RST   = 32'h0000_0000;
   localparam logic [31:0] PDS_READ_UNMAPPED    = 32'h0000_0000;
   localparam logic [3:0]  PDS_IRQ_RST          = 4'h0;
   localparam int          PDS_NUM_SINKS        = 4;
   localparam int          PDS_OFFSET_STEP_NA   = 10;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] diode_connect;
      logic       ext_a_connect;
      logic       ext_b_connect;
      logic [7:0] offset_code;
      logic       offset_enable;
      logic       idle_tristate;
   } pds_frontend_t;

   typedef struct packed {
      logic       seq_run;
      logic       integrate;
   } pds_timing_t;

   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } pds_avmm_req_t;

endpackage : pds_pkg

// ---- hdl/pds_sync.sv ----
// two-flop synchroniser for the sink headroom comparator levels
module pds_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // meta_q feeds sync_q only
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule // pds_sync

// ---- hdl/pds_input_select.sv ----
// register bank selecting the photo-amplifier inputs, with headroom flags and interrupt
//
// How it works
// - config bits 5:2 connect photodiodes one to four; reset 0
// - bits 0 and 1 connect external input pins a and b; reset 0
// - bits 15:8 give offset current code times 10nA; zero turns source off
// - bit 25: idle demod output at reference level when 0, tristated when 1
// - hardware clears headroom flag 20..23 when its sink drops below compliance
// - writing 1 sets a headroom flag; software arms each before monitoring
// - with sequencer running, diode connection also gated by diode control bits
// - manual mode 0: sequencer times integration; 1: software integrate bit
// - sequencer runs only while sequencer enable bit 0 is 1
//
// Our own choice: the Avalon-MM register port.
module pds_input_select
   import pds_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic                     resetn_i,
   // avalon-mm slave
   input  wire logic [7:0]               avs_address_i,
   input  wire logic                     avs_read_i,
   input  wire logic                     avs_write_i,
   input  wire logic [31:0]              avs_writedata_i,
   input  wire logic [3:0]               avs_byteenable_i,
   output logic      [31:0]              avs_readdata_o,
   output logic                          avs_waitrequest_o,
   // analog side
   input  wire logic [PDS_NUM_SINKS-1:0] sink_below_compliance_i,
   input  wire logic                     seq_integrate_i,
   input  wire logic [3:0]               seq_diode_phase_i,
   output pds_pkg::pds_frontend_t        frontend_o,
   output pds_pkg::pds_timing_t          timing_o,
   output logic                          irq_o
);
   import pds_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [31:0]              cfg_q;
   logic [31:0]              cfg_d;
   logic [31:0]              seq_q;
   logic [31:0]              seq_d;
   logic [PDS_NUM_SINKS-1:0] flag_q;
   logic [PDS_NUM_SINKS-1:0] flag_d;
   logic [PDS_NUM_SINKS-1:0] irq_stat_q;
   logic [PDS_NUM_SINKS-1:0] irq_stat_d;
   logic [PDS_NUM_SINKS-1:0] irq_mask_q;
   logic [PDS_NUM_SINKS-1:0] irq_mask_d;
   logic                     ack_q;
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;
   pds_frontend_t            fe_q;
   pds_frontend_t            fe_d;
   pds_timing_t              tm_q;
   pds_timing_t              tm_d;
   logic [PDS_NUM_SINKS-1:0] low_s;
   logic [PDS_NUM_SINKS-1:0] low_prev_q;

   pds_sync #(
      .WIDTH (PDS_NUM_SINKS)
   ) u_sync (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .async_i  (sink_below_compliance_i),
      .sync_o   (low_s)
   );

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // one wait cycle per access: request seen when ack_q is low, taken at the next edge with ack_q high
   wire         req      = avs_read_i | avs_write_i;
   wire         accept   = req & ack_q;
   wire         wr       = avs_write_i & accept;
   wire         sel_cfg  = (avs_address_i == PDS_INPUT_CONFIG_OFS);
   wire         sel_seq  = (avs_address_i == PDS_SEQ_CONFIG_OFS);
   wire         sel_stat = (avs_address_i == PDS_IRQ_STATUS_OFS);
   wire         sel_mask = (avs_address_i == PDS_IRQ_MASK_OFS);
   wire [31:0]  bmask    = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                            {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire [31:0]  wmasked  = avs_writedata_i & bmask;
   wire [PDS_NUM_SINKS-1:0] flag_wr1 =
      (wr & sel_cfg) ? wmasked[PDS_HEADROOM_MSB:PDS_HEADROOM_LSB] : '0;
   wire [PDS_NUM_SINKS-1:0] stat_wr1 =
      (wr & sel_stat) ? wmasked[PDS_NUM_SINKS-1:0] : '0;

   assign avs_waitrequest_o = req & ~ack_q;

   // ----------------------------------------------------------------
   // register next values
   // ----------------------------------------------------------------
   // writable fields only; headroom flags live in flag_q
   wire [31:0] cfg_wmask = 32'h0200_FF3F;
   assign cfg_d = (wr & sel_cfg) ? ((cfg_q & ~(cfg_wmask & bmask)) |
                                    (avs_writedata_i & cfg_wmask & bmask)) : cfg_q;
   assign seq_d = (wr & sel_seq) ? ((seq_q & ~bmask) | wmasked) : seq_q;
   assign irq_mask_d = (wr & sel_mask) ?
                       ((irq_mask_q & ~bmask[PDS_NUM_SINKS-1:0]) |
                        wmasked[PDS_NUM_SINKS-1:0]) : irq_mask_q;

   // ----------------------------------------------------------------
   // headroom flags and interrupt status, per sink
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PDS_NUM_SINKS; g++) begin : g_sink
         // hardware clear wins over a simultaneous software set: drop must not be hidden
         assign flag_d[g] = low_s[g] ? 1'b0 : (flag_wr1[g] | flag_q[g]);
         // event: armed flag falls; set wins over write-one-clear
         wire   ev = flag_q[g] & low_s[g] & ~low_prev_q[g];
         assign irq_stat_d[g] = ev | (irq_stat_q[g] & ~stat_wr1[g]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // front end and timing drive
   // ----------------------------------------------------------------
   wire [3:0] diode_static = cfg_q[PDS_DIODE_MSB:PDS_DIODE_LSB];
   wire       seq_run      = seq_q[PDS_SEQ_EN_BIT];
   wire [3:0] diode_gate   = seq_run ?
      (seq_q[PDS_DIODE_CTRL_MSB:PDS_DIODE_CTRL_LSB] & seq_diode_phase_i) : 4'hF;
   wire       manual       = seq_q[PDS_MANUAL_MODE_BIT];

   always_comb begin
      fe_d               = '0;
      fe_d.diode_connect = diode_static & diode_gate;
      fe_d.ext_a_connect = cfg_q[PDS_EXT_A_BIT];
      fe_d.ext_b_connect = cfg_q[PDS_EXT_B_BIT];
      fe_d.offset_code   = cfg_q[PDS_OFFSET_MSB:PDS_OFFSET_LSB];
      fe_d.offset_enable = |cfg_q[PDS_OFFSET_MSB:PDS_OFFSET_LSB];
      fe_d.idle_tristate = cfg_q[PDS_IDLE_HOLD_BIT];
      tm_d               = '0;
      tm_d.seq_run       = seq_run;
      // sequencer window counts only while it runs
      tm_d.integrate     = manual ? seq_q[PDS_SW_INTEG_BIT]
                                  : (seq_run & seq_integrate_i);
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [31:0] cfg_rd = cfg_q |
      {{(31-PDS_HEADROOM_MSB){1'b0}}, flag_q, {PDS_HEADROOM_LSB{1'b0}}};
   // read data captured in the wait cycle while ack_q is low, so it stands at the edge with waitrequest low
   assign rdata_d = ~(avs_read_i & ~ack_q) ? rdata_q :
                    sel_cfg  ? cfg_rd :
                    sel_seq  ? seq_q :
                    sel_stat ? {{(32-PDS_NUM_SINKS){1'b0}}, irq_stat_q} :
                    sel_mask ? {{(32-PDS_NUM_SINKS){1'b0}}, irq_mask_q} :
                    PDS_READ_UNMAPPED;

   // ----------------------------------------------------------------
   // flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_q      <= PDS_INPUT_CONFIG_RST;
         seq_q      <= PDS_SEQ_CONFIG_RST;
         flag_q     <= PDS_IRQ_RST;
         irq_stat_q <= PDS_IRQ_RST;
         irq_mask_q <= PDS_IRQ_RST;
         low_prev_q <= PDS_IRQ_RST;
         ack_q      <= 1'b0;
         rdata_q    <= PDS_READ_UNMAPPED;
         fe_q       <= '0;
         tm_q       <= '0;
      end else begin
         cfg_q      <= cfg_d;
         seq_q      <= seq_d;
         flag_q     <= flag_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         low_prev_q <= low_s;
         ack_q      <= req & ~ack_q;
         rdata_q    <= rdata_d;
         fe_q       <= fe_d;
         tm_q       <= tm_d;
      end
   end

   assign avs_readdata_o = rdata_q;
   assign frontend_o     = fe_q;
   assign timing_o       = tm_q;
   assign irq_o          = |(irq_stat_q & irq_mask_q);

endmodule // pds_input_select

// ---- tb/pds_input_select_props.sv ----
// checker: handshake and output relations at the photodiode input select ports
module pds_input_select_props
   import pds_pkg::*;
(
   input wire logic                   clk_i,
   input wire logic                   resetn_i,
   input wire logic                   avs_read_i,
   input wire logic                   avs_write_i,
   input wire logic [31:0]            avs_readdata_o,
   input wire logic                   avs_waitrequest_o,
   input wire logic [3:0]             sink_below_compliance_i,
   input wire logic [3:0]             seq_diode_phase_i,
   input wire pds_pkg::pds_frontend_t frontend_o,
   input wire pds_pkg::pds_timing_t   timing_o,
   input wire logic                   irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire req = avs_read_i | avs_write_i;
   wire wdone = avs_write_i & ~avs_waitrequest_o;
   one_wait_a:
      assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
   new_req_a:
      assert property ($rose(req) |-> avs_waitrequest_o) else $error("no wait state");
   idle_nowait_a:
      assert property (!req |-> !avs_waitrequest_o) else $error("wait while idle");
   offset_off_a:
      assert property (frontend_o.offset_enable == (frontend_o.offset_code != 8'h00))
         else $error("offset enable wrong");
   diode_gate_a:
      assert property (timing_o.seq_run && $past(timing_o.seq_run)
         |-> (frontend_o.diode_connect & ~$past(seq_diode_phase_i)) == 4'h0)
         else $error("diode not gated");
   rdata_hold_a:
      assert property ($changed(avs_readdata_o) |-> $past(avs_read_i)) else $error("rdata moved");
   irq_cause_a:
      assert property ($rose(irq_o) |-> $past(wdone) ||
         ($past(sink_below_compliance_i, 3) & ~$past(sink_below_compliance_i, 4)) != 4'h0)
         else $error("irq without cause");
   fe_stable_a:
      assert property ($changed(frontend_o) && !$past(timing_o.seq_run) |-> $past(wdone, 2))
         else $error("frontend moved");
   cover property (wdone);
   cover property (avs_read_i && !avs_waitrequest_o);
   cover property ($rose(irq_o));
endmodule // pds_input_select_props

bind pds_input_select pds_input_select_props u_props (.clk_i, .resetn_i, .avs_read_i,
   .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .sink_below_compliance_i,
   .seq_diode_phase_i, .frontend_o, .timing_o, .irq_o);

// ---- tb/tb_top.sv ----
// testbench: register access, headroom flags, interrupt and sequencer gating
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pds_pkg::*;
   logic clk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, seq_integrate_i = 0;
   logic [7:0] avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
   logic [3:0] avs_byteenable_i = 4'hf, sink_below_compliance_i = 4'h0;
   logic [3:0] seq_diode_phase_i = 4'h0;
   logic avs_waitrequest_o, irq_o;
   pds_frontend_t frontend_o;
   pds_timing_t timing_o;
   int n_errors = 0, tests_run = 0;
   pds_input_select uut (.clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
      .sink_below_compliance_i, .seq_integrate_i, .seq_diode_phase_i, .frontend_o,
      .timing_o, .irq_o);
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // bus access and settling
   // ----------------------------------------------------------------
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= ~w;
      avs_writedata_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 64);
      q = avs_readdata_o;
      if (n == 64) n_errors++;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask
   task automatic settle;
      repeat (6) @(negedge clk_i);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_config;
      bus(PDS_INPUT_CONFIG_OFS, 0, 0);
      `CHK("cfg rst", PDS_INPUT_CONFIG_RST, q)
      bus(PDS_INPUT_CONFIG_OFS, 1, 32'hffff_ffff);
      bus(PDS_INPUT_CONFIG_OFS, 0, 0);
      `CHK("cfg all", 32'h02f0_ff3f, q)
      settle;
      `CHK("fe all", 16'hffff, frontend_o)
      bus(PDS_INPUT_CONFIG_OFS, 1, 32'h0000_0125);
      settle;
      `CHK("fe mix", 16'h9806, frontend_o)
      bus(PDS_INPUT_CONFIG_OFS, 1, 32'h0000_0002);
      settle;
      `CHK("fe off", 16'h0400, frontend_o)
   endtask
   task automatic t_headroom;
      bus(PDS_IRQ_MASK_OFS, 1, 32'h0000_0003);
      @(posedge clk_i) sink_below_compliance_i <= 4'h2;
      settle;
      `CHK("irq drop", 1'b1, irq_o)
      bus(PDS_INPUT_CONFIG_OFS, 0, 0);
      `CHK("flag clr", 32'h00d0_0002, q)
      bus(PDS_IRQ_STATUS_OFS, 1, 32'h0000_0002);
      settle;
      `CHK("irq w1c", 1'b0, irq_o)
      @(posedge clk_i) sink_below_compliance_i <= 4'h6;
      settle;
      `CHK("irq masked", 1'b0, irq_o)
      bus(PDS_IRQ_STATUS_OFS, 0, 0);
      `CHK("status", 32'h0000_0004, q)
      bus(PDS_IRQ_MASK_OFS, 1, 32'h0000_0007);
      settle;
      `CHK("irq unmask", 1'b1, irq_o)
      bus(PDS_IRQ_STATUS_OFS, 1, 32'h0000_0004);
      settle;
      `CHK("irq clear", 1'b0, irq_o)
   endtask
   task automatic t_seq;
      @(posedge clk_i) seq_diode_phase_i <= 4'h3;
      seq_integrate_i <= 1'b1;
      bus(PDS_INPUT_CONFIG_OFS, 1, 32'h0000_003c);
      bus(PDS_SEQ_CONFIG_OFS, 1, 32'h0005_0001);
      settle;
      `CHK("gated", 4'h1, frontend_o.diode_connect)
      `CHK("seq run", 1'b1, timing_o.seq_run)
      `CHK("seq integ", 1'b1, timing_o.integrate)
      @(posedge clk_i) seq_integrate_i <= 1'b0;
      settle;
      `CHK("seq integ0", 1'b0, timing_o.integrate)
      bus(PDS_SEQ_CONFIG_OFS, 1, 32'h0035_0001);
      settle;
      `CHK("sw integ", 1'b1, timing_o.integrate)
      bus(PDS_SEQ_CONFIG_OFS, 1, 32'h0000_0000);
      settle;
      `CHK("seq stop", 1'b0, timing_o.seq_run)
      `CHK("static", 4'hf, frontend_o.diode_connect)
   endtask
   task automatic t_unmapped;
      bus(8'h10, 1, 32'hffff_ffff);
      bus(8'h10, 0, 0);
      `CHK("unmapped", PDS_READ_UNMAPPED, q)
      bus(PDS_INPUT_CONFIG_OFS, 0, 0);
      `CHK("cfg kept", 32'h0090_003c, q)
   endtask
   task automatic results;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_config;
      t_headroom;
      t_seq;
      t_unmapped;
      results;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      results;
   end
endmodule // tb_top
